// ---- inc/sere_cfg.svh ----
// Constants of the serial EEPROM read/write engine.
`ifndef SERE_CFG_SVH
`define SERE_CFG_SVH

// ****************************************************************
// Device address and array layout
// ****************************************************************
`define SERE_TYPE_CODE      4'ha
`define SERE_AW_DEFAULT     8
`define SERE_OFS_W          4
`define SERE_BYTE_W         8
`define SERE_BYTE_BITS      4'h8
`define SERE_ERASED         8'hff
`define SERE_PAGE_SEL_MAX   3

// ****************************************************************
// Buffering and timing
// ****************************************************************
`define SERE_FIFO_DEPTH     8
`define SERE_CLK_MHZ        50
`define SERE_PROG_TIME_US   3000

`endif

// ---- inc/sere_pkg.sv ----
// Types shared by the serial EEPROM read/write engine.
package sere_pkg;

    // ****************************************************************
    // Bus engine states and received byte kinds
    // ****************************************************************
    typedef enum logic [2:0] {
        SERE_ST_IDLE,
        SERE_ST_RX,
        SERE_ST_ACK,
        SERE_ST_TX,
        SERE_ST_MACK,
        SERE_ST_PROG
    } sere_state_e;

    typedef enum logic [1:0] {
        SERE_K_DEV,
        SERE_K_WORD,
        SERE_K_DATA
    } sere_kind_e;

    // ****************************************************************
    // One received write byte and its place within the page
    // ****************************************************************
    typedef struct packed {
        logic [3:0] offset;
        logic [7:0] data;
    } sere_wbyte_s;

endpackage

// ---- core/sere_mem.sv ----
// Simple dual-port memory with a registered read port and a preset content.
`timescale 1ns/100ps
`default_nettype none

module sere_mem #(
    parameter int          DW   = 8,
    parameter int          AW   = 8,
    parameter logic [7:0]  INIT = 8'hff
) (
    input  wire logic          clk_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // Every cell starts erased; there is no reset for the array itself.
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem_r[i] = DW'(INIT);
        end
    end

    // Write port.
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    // Read data comes out of a register, one cycle after the address.
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_r[rd_addr_i];
    end

endmodule

`default_nettype wire

// ---- core/sere_engine.sv ----
// Two-wire serial EEPROM command engine with its write FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "sere_cfg.svh"

// ****************************************************************
// Write byte FIFO
// ****************************************************************
module sere_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] buf_r [0:DEPTH-1];
    logic [PW:0]  wptr_r;
    logic [PW:0]  rptr_r;
    logic         full;
    logic         empty;

    // An extra pointer bit tells full from empty.
    assign full        = (wptr_r[PW] != rptr_r[PW]) && (wptr_r[PW-1:0] == rptr_r[PW-1:0]);
    assign empty       = (wptr_r == rptr_r);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = buf_r[rptr_r[PW-1:0]];

    // Storage.
    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            buf_r[wptr_r[PW-1:0]] <= in_data_i;
        end
    end

    // Pointers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end

endmodule

// ****************************************************************
// Engine top
// ****************************************************************
// Overview of operation
// - Byte write: word address and one data byte are acknowledged, then stop.
// - After the stop ending a write, a self-timed program cycle ignores the bus.
// - Page write: up to fifteen more bytes, each acknowledged, ended by stop.
// - During writes only the low four address bits advance, wrapping in page.
// - More than sixteen bytes wrap in page, later bytes replace earlier ones.
// - Busy device ignores its address; afterwards it acknowledges and proceeds.
// - Program time runs from the ending stop to the end of programming.
// - Write-protect low allows writes; high protects the whole array.
// - Address counter holds last accessed location plus one, kept between transfers.
// - Reads wrap from the last byte of memory to the first.
// - Current-address read sends the byte at the counter; master nacks and stops.
// - Each master acknowledge advances the address and sends the next byte.
// - A nack then stop ends a sequential read; the data line is released.
// - The factory array content reads as all ones.
// - Device address holds type code, zero or page-select bits, direction last.
// - Matching address is acknowledged; a mismatch returns to standby.
// - Array is 16 to 128 pages of sixteen bytes, address 8 to 11 bits.
module sere_engine
    import sere_pkg::*;
#(
    parameter int AW          = `SERE_AW_DEFAULT,
    parameter int PROG_CYCLES = `SERE_PROG_TIME_US * `SERE_CLK_MHZ
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    input  wire logic wp_i,
    output logic      busy_o
);

    import sere_pkg::*;

    localparam int PB = AW - `SERE_BYTE_W;
    localparam int TW = $clog2(PROG_CYCLES + 1);

    // ****************************************************************
    // Pin synchronisers and bus events
    // ****************************************************************
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic wp_s1_r, wp_s2_r;

    // Two flops for every pin; the third stage only serves edge detection.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
            {wp_s1_r, wp_s2_r}             <= 2'h3;
        end else begin
            {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_i, scl_s1_r, scl_s2_r};
            {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_i, sda_s1_r, sda_s2_r};
            {wp_s1_r, wp_s2_r}             <= {wp_i, wp_s1_r};
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;

    // Data changes while the clock is high mark start and stop.
    assign scl_rise  = scl_s2_r & ~scl_s3_r;
    assign scl_fall  = ~scl_s2_r & scl_s3_r;
    assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
    assign stop_det  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Type code must match and unused select bits must be zero.
    function automatic logic dev_match(input logic [7:0] b);
        logic ok;
        ok = (b[7:4] == `SERE_TYPE_CODE);
        for (int i = PB; i < `SERE_PAGE_SEL_MAX; i++) begin
            ok = ok & ~b[i+1];
        end
        return ok;
    endfunction

    // Next address inside the current page only.
    function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
        return {a[AW-1:`SERE_OFS_W], a[`SERE_OFS_W-1:0] + 4'h1};
    endfunction

    // ****************************************************************
    // Bus engine
    // ****************************************************************
    sere_state_e state_r;
    sere_kind_e  kind_r;
    logic        rnw_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic        oe_r;
    logic        wr_pend_r;
    logic        prog_done;
    logic [7:0]  arr_rdata;
    logic        active;
    logic        byte_done;
    logic        tx_load;

    assign active    = (state_r != SERE_ST_PROG) && !start_det && !stop_det;
    assign byte_done = active && (state_r == SERE_ST_RX) && scl_fall && (bit_cnt_r == `SERE_BYTE_BITS);
    assign tx_load   = active && scl_fall &&
                       (((state_r == SERE_ST_ACK) && (kind_r == SERE_K_DEV) && rnw_r) ||
                        (state_r == SERE_ST_MACK));

    // Byte framing, acknowledge driving and transmit shifting.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r   <= SERE_ST_IDLE;
            kind_r    <= SERE_K_DEV;
            rnw_r     <= 1'b0;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            oe_r      <= 1'b0;
        end else if (state_r == SERE_ST_PROG) begin
            oe_r <= 1'b0;
            if (prog_done) begin
                state_r <= SERE_ST_IDLE;
            end
        end else if (start_det) begin
            state_r   <= SERE_ST_RX;
            kind_r    <= SERE_K_DEV;
            bit_cnt_r <= 4'h0;
            oe_r      <= 1'b0;
        end else if (stop_det) begin
            oe_r    <= 1'b0;
            state_r <= (wr_pend_r && !wp_s2_r) ? SERE_ST_PROG : SERE_ST_IDLE;
        end else begin
            case (state_r)
                SERE_ST_RX: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s2_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_r <= 4'h0;
                        if (kind_r != SERE_K_DEV || dev_match(shift_r)) begin
                            oe_r    <= 1'b1;
                            state_r <= SERE_ST_ACK;
                        end else begin
                            state_r <= SERE_ST_IDLE;
                        end
                        if (kind_r == SERE_K_DEV) begin
                            rnw_r <= shift_r[0];
                        end
                    end
                end
                SERE_ST_ACK: begin
                    if (tx_load) begin
                        shift_r   <= arr_rdata;
                        oe_r      <= ~arr_rdata[7];
                        bit_cnt_r <= 4'h1;
                        state_r   <= SERE_ST_TX;
                    end else if (scl_fall) begin
                        oe_r    <= 1'b0;
                        state_r <= SERE_ST_RX;
                        kind_r  <= (kind_r == SERE_K_DEV) ? SERE_K_WORD : SERE_K_DATA;
                    end
                end
                SERE_ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == `SERE_BYTE_BITS) begin
                            oe_r    <= 1'b0;
                            state_r <= SERE_ST_MACK;
                        end else begin
                            oe_r      <= ~shift_r[6];
                            shift_r   <= {shift_r[6:0], 1'b1};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                SERE_ST_MACK: begin
                    if (scl_rise && sda_s2_r) begin
                        state_r <= SERE_ST_IDLE;
                    end else if (tx_load) begin
                        shift_r   <= arr_rdata;
                        oe_r      <= ~arr_rdata[7];
                        bit_cnt_r <= 4'h1;
                        state_r   <= SERE_ST_TX;
                    end
                end
                default: begin
                    oe_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Address counter and page select capture
    // ****************************************************************
    logic [AW-1:0] addr_r;
    logic [2:0]    psel_r;

    // The counter survives transfers; only the word address reloads it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_r <= '0;
            psel_r <= 3'h0;
        end else if (byte_done) begin
            case (kind_r)
                SERE_K_DEV: begin
                    psel_r <= shift_r[3:1];
                end
                SERE_K_WORD: begin
                    addr_r <= AW'({psel_r, shift_r});
                end
                SERE_K_DATA: begin
                    addr_r <= page_inc(addr_r);
                end
                default: begin
                    addr_r <= addr_r;
                end
            endcase
        end else if (tx_load) begin
            addr_r <= addr_r + 1'b1;
        end
    end

    // ****************************************************************
    // Write byte capture into the FIFO
    // ****************************************************************
    sere_wbyte_s push_r;
    logic        push_vld_r;
    logic        fifo_in_rdy;
    logic        fifo_out_vld;
    logic [11:0] fifo_out_raw;
    sere_wbyte_s fifo_out;

    // A byte waits here until the FIFO accepts it; programming waits for it too.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            push_r     <= '0;
            push_vld_r <= 1'b0;
        end else if (byte_done && kind_r == SERE_K_DATA) begin
            push_r     <= '{offset: addr_r[`SERE_OFS_W-1:0], data: shift_r};
            push_vld_r <= 1'b1;
        end else if (fifo_in_rdy) begin
            push_vld_r <= 1'b0;
        end
    end

    // A write is pending once a data byte arrived; a new start abandons it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_r <= 1'b0;
        end else if (byte_done && kind_r == SERE_K_DATA) begin
            wr_pend_r <= 1'b1;
        end else if (start_det || stop_det) begin
            wr_pend_r <= 1'b0;
        end
    end

    sere_fifo #(
        .W     (12),
        .DEPTH (`SERE_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_vld_r),
        .in_ready_o  (fifo_in_rdy),
        .in_data_i   (push_r),
        .out_valid_o (fifo_out_vld),
        .out_ready_i (1'b1),
        .out_data_o  (fifo_out_raw)
    );

    assign fifo_out = sere_wbyte_s'(fifo_out_raw);

    // ****************************************************************
    // Page staging buffer and its valid bits
    // ****************************************************************
    logic [15:0] stg_vld_r;
    logic [4:0]  copy_idx_r;
    logic        copy_wr_r;
    logic [3:0]  copy_ofs_r;
    logic [7:0]  stg_rdata;
    logic        drained;

    // Later bytes at the same offset simply overwrite the staged one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stg_vld_r <= 16'h0000;
        end else begin
            if ((start_det && state_r != SERE_ST_PROG) || prog_done ||
                (stop_det && state_r != SERE_ST_PROG && wp_s2_r)) begin
                stg_vld_r <= 16'h0000;
            end
            if (fifo_out_vld) begin
                stg_vld_r[fifo_out.offset] <= 1'b1;
            end
        end
    end

    sere_mem #(
        .DW   (`SERE_BYTE_W),
        .AW   (`SERE_OFS_W),
        .INIT (`SERE_ERASED)
    ) u_stage (
        .clk_i     (clk_i),
        .wr_en_i   (fifo_out_vld),
        .wr_addr_i (fifo_out.offset),
        .wr_data_i (fifo_out.data),
        .rd_addr_i (copy_idx_r[3:0]),
        .rd_data_o (stg_rdata)
    );

    // ****************************************************************
    // Program cycle
    // ****************************************************************
    logic [TW-1:0] tmr_r;

    assign drained   = !fifo_out_vld && !push_vld_r;
    assign prog_done = (state_r == SERE_ST_PROG) && (tmr_r >= TW'(PROG_CYCLES - 1)) &&
                       copy_idx_r[4] && !copy_wr_r;

    // Timer runs from the stop; the page copy overlaps its start.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_r      <= '0;
            copy_idx_r <= 5'h00;
            copy_wr_r  <= 1'b0;
            copy_ofs_r <= 4'h0;
        end else if (state_r != SERE_ST_PROG) begin
            tmr_r      <= '0;
            copy_idx_r <= 5'h00;
            copy_wr_r  <= 1'b0;
        end else begin
            if (tmr_r < TW'(PROG_CYCLES - 1)) begin
                tmr_r <= tmr_r + 1'b1;
            end
            copy_wr_r <= drained && !copy_idx_r[4];
            if (drained && !copy_idx_r[4]) begin
                copy_ofs_r <= copy_idx_r[3:0];
                copy_idx_r <= copy_idx_r + 5'h01;
            end
        end
    end

    // ****************************************************************
    // Array
    // ****************************************************************
    sere_mem #(
        .DW   (`SERE_BYTE_W),
        .AW   (AW),
        .INIT (`SERE_ERASED)
    ) u_array (
        .clk_i     (clk_i),
        .wr_en_i   (copy_wr_r && stg_vld_r[copy_ofs_r]),
        .wr_addr_i ({addr_r[AW-1:`SERE_OFS_W], copy_ofs_r}),
        .wr_data_i (stg_rdata),
        .rd_addr_i (addr_r),
        .rd_data_o (arr_rdata)
    );

    // Open-drain pin: only ever pulls low.
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_r;
    assign busy_o   = (state_r == SERE_ST_PROG);

endmodule

`default_nettype wire

// ---- verif/sere_engine_assertions.sv ----
// Port checker of the serial EEPROM engine, bound to its top.
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module sere_chk #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic wp_i,
    input wire logic busy_o
);
    int cnt_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Clocks spent in the current program cycle.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            cnt_r <= 0;
        else
            cnt_r <= busy_o ? cnt_r + 1 : 0;
    end
    // The window of two clocks on the cycle length allows for the stop detector.
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("sda_o not low");
    busy_quiet_a: assert property (busy_o |-> !sda_oe_o)
        else $error("bus driven while busy");
    busy_hold_a: assert property ($rose(busy_o) |=> busy_o [*8])
        else $error("program cycle cut short");
    busy_len_a: assert property ($fell(busy_o) |-> cnt_r >= PROG_CYCLES - 2 && cnt_r <= PROG_CYCLES + 2)
        else $error("program cycle length wrong");
    busy_max_a: assert property (cnt_r <= PROG_CYCLES + 2)
        else $error("program cycle too long");
    wp_skip_a: assert property ($rose(busy_o) |-> !$past(wp_i, 3))
        else $error("program under write protect");
    stop_first_a: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("program without stop");
    scl_low_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
        else $error("data changed while clock high");
    cover property ($rose(busy_o));
    cover property ($rose(sda_oe_o));
    cover property (wp_i && $rose(sda_i) && scl_i);
endmodule
bind sere_engine sere_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .busy_o(busy_o));
`default_nettype wire

// ---- verif/sere_master.sv ----
// Two-wire bus master model that drives the engine's link.
`timescale 1ns/100ps
`default_nettype none
module sere_master (
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    // The clock stands high between frames; the data line is only ever pulled low.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Start or repeated start; the wait lets a pending acknowledge be released first.
    task automatic start();
        #20 sda_low_o = 1'b0;
        #100 scl_o = 1'b1;
        #40 sda_low_o = 1'b1;
        #40 scl_o = 1'b0;
    endtask
    // Stop ends a write or a read after the final no acknowledge.
    task automatic stop();
        #20 sda_low_o = 1'b1;
        #100 scl_o = 1'b1;
        #40 sda_low_o = 1'b0;
    endtask
    // Nine bits, MSB first; a one releases the line, samples taken mid-high.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #20 sda_low_o = ~tx[i];
            #60 scl_o = 1'b1;
            #40 rx[i] = sda_i;
            #40 scl_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench of the serial EEPROM engine.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sere_pkg::*;
    localparam int PC = 200;
    logic clk, rst_n, wp, scl, m_low, sda, sda_o, sda_oe, busy;
    logic [7:0] a, d, nk;
    int n_fail = 0;
    int n_checks = 0;
    // Wired-AND of both pull-downs with the pull-up.
    assign sda = ~(m_low | sda_oe);
    sere_engine #(.AW(8), .PROG_CYCLES(PC)) uut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .busy_o(busy));
    sere_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] b, output logic [7:0] ak);
        logic [8:0] r;
        m.xfer({b, 1'b1}, r);
        ak = {7'h0, ~r[0]};
    endtask
    task automatic rb(input logic last, output logic [7:0] v);
        logic [8:0] r;
        m.xfer({8'hff, last}, r);
        v = r[8:1];
    endtask
    // Polls until acknowledged; the first answer is kept apart.
    task automatic poll(input logic [7:0] b, output logic [7:0] first);
        a = 8'h00;
        for (int n = 0; n < 20 && a != 8'h01; n++) begin
            if (n > 0)
                m.stop();
            m.start();
            wb(b, a);
            if (n == 0)
                first = a;
        end
    endtask
    task automatic seek(input logic [7:0] wa);
        m.start();
        wb(8'ha0, a);
        wb(wa, a);
        m.start();
        wb(8'ha1, a);
        check(a, 8'h01);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_erased();
        logic [7:0] bad [3];
        bad = '{8'h51, 8'ha2, 8'ha8};
        m.start();
        wb(8'ha1, a);
        check(a, 8'h01);
        rb(1'b1, d);
        check(d, 8'hff);
        m.stop();
        foreach (bad[i]) begin
            m.start();
            wb(bad[i], a);
            check(a, 8'h00);
            m.stop();
        end
    endtask
    // Eighteen bytes from offset 14: offsets 14 and 15 are overwritten by the last two.
    task automatic t_page();
        m.start();
        wb(8'ha0, a);
        wb(8'h1e, a);
        for (int i = 0; i < 18; i++) begin
            wb(8'h30 + 8'(i), a);
            check(a, 8'h01);
        end
        m.stop();
        repeat (10) @(posedge clk);
        #2;
        check({7'h0, busy}, 8'h01);
        poll(8'ha1, nk);
        check(nk, 8'h00);
        check(a, 8'h01);
        rb(1'b1, d);
        check(d, 8'h32);
        m.stop();
        seek(8'h10);
        for (int k = 0; k < 17; k++) begin
            rb(k == 16, d);
            check(d, k < 16 ? 8'h32 + 8'(k) : 8'hff);
        end
        m.stop();
    endtask
    task automatic t_wrap();
        m.start();
        wb(8'ha0, a);
        wb(8'h00, a);
        wb(8'h5a, a);
        m.stop();
        poll(8'ha1, nk);
        check(a, 8'h01);
        rb(1'b1, d);
        check(d, 8'hff);
        m.stop();
        seek(8'hff);
        rb(1'b0, d);
        check(d, 8'hff);
        rb(1'b1, d);
        check(d, 8'h5a);
        m.stop();
    endtask
    task automatic t_protect();
        @(posedge clk) #2 wp = 1'b1;
        m.start();
        wb(8'ha0, a);
        wb(8'h10, a);
        wb(8'h00, a);
        check(a, 8'h01);
        m.stop();
        repeat (10) @(posedge clk);
        #2;
        check({7'h0, busy}, 8'h00);
        @(posedge clk) #2 wp = 1'b0;
        seek(8'h10);
        rb(1'b1, d);
        check(d, 8'h32);
        m.stop();
    endtask
    // ****************************************************************
    // Clock, sequence and watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #500000;
        n_fail++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        repeat (10) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (5) @(posedge clk);
        #2;
        t_erased();
        t_page();
        t_wrap();
        t_protect();
        stop_test();
    end
endmodule
`default_nettype wire
